// ---- src/stc_converter.sv ----
/*
 Seven track data converter: packs channel bytes into tape characters on
 write, unpacks tape characters into bytes on forward read, passes data
 through otherwise. Assumes synchronous inputs on clk_in and that each
 side holds its valid until ready is seen.
*/
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Convert only on seven-track writes and seven-track forward reads.
// - Backward read bypasses conversion but keeps the enable state.
// - Control output bit 2 set at operation start disables conversion.
// - Control output bit 2 clear at operation start enables conversion.
// - Write packs three channel bytes into four tape characters.
// - Short final write group fills unused character bits with zeros.
// - Forward read assembles four tape characters into three bytes.
// - Short read group zero-fills last byte and flags a convert check.
module stc_converter (
   input  wire logic                   clk_in,
   input  wire logic                   nrst_in,
   input  wire logic                   tape_operation_active_in,
   input  wire logic [7:0]             mp1_control_output_a_in,
   input  wire logic                   seven_track_in,
   input  wire stc_pkg::stc_op_t       op_kind_in,
   input  wire logic                   end_of_block_in,
   input  wire logic                   in_valid_in,
   input  wire logic [7:0]             in_data_in,
   input  wire logic                   in_parity_in,
   output logic                        in_ready_out,
   output logic                        out_valid_out,
   output logic [7:0]                  out_data_out,
   output logic                        out_parity_out,
   input  wire logic                   out_ready_in,
   output logic                        conv_enabled_out,
   output logic                        convert_check_out
);
   logic        conv_en_r,    conv_en_nxt;
   logic        op_prev_r,    op_prev_nxt;
   logic [23:0] acc_r,        acc_nxt;
   logic [1:0]  cnt_r,        cnt_nxt;
   logic [1:0]  emit_r,       emit_nxt;
   logic        busy_r,       busy_nxt;
   logic [7:0]  dout_r,       dout_nxt;
   logic        dpar_r,       dpar_nxt;
   logic        dval_r,       dval_nxt;
   logic        chk_r,        chk_nxt;
   logic        convert;
   logic        is_write;
   logic        take;
   logic [1:0]  last_emit;
   logic        op_rise;
   logic        tail_flush;
   logic        char_par;
   logic        byte_par;

   assign is_write = (op_kind_in == stc_pkg::STC_OP_WRITE);
   assign convert  = conv_en_r && seven_track_in &&
                     (is_write || op_kind_in == stc_pkg::STC_OP_READ_FWD);

   assign in_ready_out      = !busy_r && (!dval_r || out_ready_in);
   assign take              = in_valid_in && in_ready_out;
   assign out_valid_out     = dval_r;
   assign out_data_out      = dout_r;
   assign out_parity_out    = dpar_r;
   assign conv_enabled_out  = conv_en_r;
   assign convert_check_out = chk_r;
   assign op_rise           = tape_operation_active_in && !op_prev_r;
   assign tail_flush        = end_of_block_in && convert &&
                              (cnt_r != 2'h0) && !busy_r && !take;

   // Odd parity for tape characters and channel bytes
   stc_odd_parity #(
      .DATA_W (stc_pkg::CHAR_W)
   ) u_char_par (
      .data_in    (acc_r[23:18]),
      .parity_out (char_par)
   );
   stc_odd_parity #(
      .DATA_W (stc_pkg::BYTE_W)
   ) u_byte_par (
      .data_in    (acc_r[23:16]),
      .parity_out (byte_par)
   );

   // Characters less one to emit for a short write group, bytes less one for a short read
   always_comb begin
      if (is_write) begin
         last_emit = (cnt_r == 2'h1) ? 2'h1 : 2'h2;
      end else begin
         last_emit = cnt_r - 2'h1;
      end
   end

   always_comb begin
      acc_nxt     = acc_r;
      cnt_nxt     = cnt_r;
      emit_nxt    = emit_r;
      busy_nxt    = busy_r;
      dout_nxt    = dout_r;
      dpar_nxt    = dpar_r;
      dval_nxt    = dval_r && !out_ready_in;
      // Operation start clears group state
      if (op_rise) begin
         acc_nxt     = stc_pkg::ACC_RST;
         cnt_nxt     = stc_pkg::PHASE_RST;
         busy_nxt    = 1'b0;
      end else if (busy_r) begin
         if (!dval_r || out_ready_in) begin
            dval_nxt = 1'b1;
            if (is_write) begin
               dout_nxt = {2'b00, acc_r[23:18]};
               dpar_nxt = char_par;
               acc_nxt  = {acc_r[17:0], 6'h00};
            end else begin
               dout_nxt = acc_r[23:16];
               dpar_nxt = byte_par;
               acc_nxt  = {acc_r[15:0], 8'h00};
            end
            emit_nxt = emit_r - 2'h1;
            if (emit_r == 2'h0) begin
               busy_nxt = 1'b0;
               acc_nxt  = stc_pkg::ACC_RST;
            end
         end
      end else if (take && !convert) begin
         dout_nxt = in_data_in;
         dpar_nxt = in_parity_in;
         dval_nxt = 1'b1;
      end else if (take && is_write) begin
         // three bytes gather into four characters
         acc_nxt = acc_r | ({in_data_in, 16'h0000} >> (8 * cnt_r));
         if (cnt_r == 2'(stc_pkg::BYTES_PER_GRP - 1)) begin
            cnt_nxt  = stc_pkg::PHASE_RST;
            emit_nxt = 2'(stc_pkg::CHARS_PER_GRP - 1);
            busy_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 2'h1;
         end
      end else if (take) begin
         // four characters gather into three bytes
         acc_nxt = acc_r |
                   ({in_data_in[5:0], 18'h00000} >> (6 * cnt_r));
         if (cnt_r == 2'(stc_pkg::CHARS_PER_GRP - 1)) begin
            cnt_nxt  = stc_pkg::PHASE_RST;
            emit_nxt = 2'(stc_pkg::BYTES_PER_GRP - 1);
            busy_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 2'h1;
         end
      end else if (tail_flush) begin
         emit_nxt = last_emit;
         busy_nxt = 1'b1;
         cnt_nxt  = stc_pkg::PHASE_RST;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         acc_r     <= stc_pkg::ACC_RST;
         cnt_r     <= stc_pkg::PHASE_RST;
         emit_r    <= stc_pkg::PHASE_RST;
         busy_r    <= 1'b0;
         dout_r    <= 8'h00;
         dpar_r    <= 1'b0;
         dval_r    <= 1'b0;
      end else begin
         acc_r     <= acc_nxt;
         cnt_r     <= cnt_nxt;
         emit_r    <= emit_nxt;
         busy_r    <= busy_nxt;
         dout_r    <= dout_nxt;
         dpar_r    <= dpar_nxt;
         dval_r    <= dval_nxt;
      end
   end

   // Mode group: operation start edge and convert check
   always_comb begin
      op_prev_nxt = tape_operation_active_in;
      conv_en_nxt = conv_en_r;
      chk_nxt     = chk_r;
      // bit 2 set at operation rise disables
      // bit 2 clear at operation rise enables
      if (op_rise) begin
         conv_en_nxt = !mp1_control_output_a_in[stc_pkg::DISABLE_BIT];
         chk_nxt     = 1'b0;
      end else if (tail_flush && !is_write) begin
         chk_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         conv_en_r <= stc_pkg::CONV_EN_RST;
         op_prev_r <= 1'b0;
         chk_r     <= 1'b0;
      end else begin
         conv_en_r <= conv_en_nxt;
         op_prev_r <= op_prev_nxt;
         chk_r     <= chk_nxt;
      end
   end
endmodule

// Odd parity over one data word
module stc_odd_parity #(
   parameter int unsigned DATA_W = 8
) (
   input  wire logic [DATA_W-1:0] data_in,
   output logic                   parity_out
);
   assign parity_out = ~^data_in;
endmodule

`default_nettype wire

// ---- src/stc_pkg.sv ----
/*
 Package for the seven track data converter: operation kinds, widths,
 reset values and group sizes. Assumes one clock domain.
*/
package stc_pkg;
   typedef enum logic [1:0] {
      STC_OP_OTHER,
      STC_OP_WRITE,
      STC_OP_READ_FWD,
      STC_OP_READ_BWD
   } stc_op_t;
   localparam int unsigned BYTE_W        = 8;
   localparam int unsigned CHAR_W        = 6;
   localparam int unsigned DISABLE_BIT   = 2;
   localparam int unsigned BYTES_PER_GRP = 3;
   localparam int unsigned CHARS_PER_GRP = 4;
   localparam logic        CONV_EN_RST   = 1'b1;
   localparam logic [1:0]  PHASE_RST     = 2'h0;
   localparam logic [23:0] ACC_RST       = 24'h000000;
endpackage

// ---- test/stc_sink.sv ----
/* Consumer model on the converter output.
 Ready toggles each cycle while slow_in is high, else stays up. */
`timescale 1ns/100ps
`default_nettype none
module stc_sink (
   input  wire logic clk_in,
   input  wire logic slow_in,
   output logic      ready_out
);
   always_ff @(posedge clk_in) ready_out <= slow_in ? !ready_out : 1'b1;
endmodule
`default_nettype wire

// ---- test/stc_converter_checker.sv ----
/* Port checker for stc_converter.
 Bound to every stc_converter instance. */
`timescale 1ns/100ps
`default_nettype none
module stc_converter_checker (
   input wire logic             clk_in,
   input wire logic             nrst_in,
   input wire logic             tape_operation_active_in,
   input wire logic [7:0]       mp1_control_output_a_in,
   input wire logic             seven_track_in,
   input wire stc_pkg::stc_op_t op_kind_in,
   input wire logic             in_valid_in,
   input wire logic [7:0]       in_data_in,
   input wire logic             in_ready_out,
   input wire logic             out_valid_out,
   input wire logic [7:0]       out_data_out,
   input wire logic             out_ready_in,
   input wire logic             conv_enabled_out,
   input wire logic             convert_check_out
);
   wire wr = op_kind_in == stc_pkg::STC_OP_WRITE;
   wire conv = seven_track_in && conv_enabled_out &&
      (wr || op_kind_in == stc_pkg::STC_OP_READ_FWD);
   wire held = out_valid_out && !out_ready_in;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   chk_hold_out: assert property (held |=>
      out_valid_out && $stable(out_data_out)) else $error("output dropped");
   chk_no_take: assert property (held |-> !in_ready_out)
      else $error("input taken while held");
   chk_mode_off:
      assert property ($rose(tape_operation_active_in) &&
      mp1_control_output_a_in[2] |=> !conv_enabled_out) else $error("not off");
   chk_mode_on:
      assert property ($rose(tape_operation_active_in) &&
      !mp1_control_output_a_in[2] |=> conv_enabled_out) else $error("not on");
   chk_en_keep:
      assert property (!$rose(tape_operation_active_in) |=>
      $stable(conv_enabled_out)) else $error("enable changed");
   chk_check_clr:
      assert property ($rose(tape_operation_active_in) |=>
      !convert_check_out) else $error("check not cleared");
   chk_write_pad:
      assert property (conv && wr && out_valid_out |->
      out_data_out[7:6] == 2'h0) else $error("high char bits set");
   chk_bypass_data:
      assert property (in_valid_in && in_ready_out && !conv &&
      tape_operation_active_in && !$rose(tape_operation_active_in) |=>
      out_valid_out && out_data_out == $past(in_data_in)) else $error("bypass");
   cover property ($rose(convert_check_out));
   cover property (conv && held);
   cover property ($fell(conv_enabled_out));
endmodule
bind stc_converter stc_converter_checker u_chk (.*);
`default_nettype wire

// ---- test/seven_track_data_converter_tb.sv ----
/* Testbench for stc_converter, stc_sink as consumer.
 Mode, write, read, bypass and nine-track cases; parity checked. */
`timescale 1ns/100ps
`default_nettype none
module seven_track_data_converter_tb;
   logic             clk = 0, nrst = 0, top = 0, vld = 0, par = 0, eob = 0;
   logic             slow = 0, rdy, seven = 1;
   logic             gp[$];
   logic [7:0]       mp1 = 0, din = 0;
   logic [7:0]       got[$];
   stc_pkg::stc_op_t op = stc_pkg::STC_OP_OTHER;
   int               n_mismatch = 0, tests_run = 0;
   wire              irdy, ov, en, ck, opar;
   wire [7:0]        dout;
   initial forever #2.5 clk = !clk;
   stc_converter DUT (.clk_in(clk), .nrst_in(nrst),
      .tape_operation_active_in(top), .mp1_control_output_a_in(mp1),
      .seven_track_in(seven), .op_kind_in(op), .end_of_block_in(eob),
      .in_valid_in(vld), .in_data_in(din), .in_parity_in(par),
      .in_ready_out(irdy), .out_valid_out(ov), .out_data_out(dout),
      .out_parity_out(opar), .out_ready_in(rdy), .conv_enabled_out(en),
      .convert_check_out(ck));
   stc_sink u_sink (.clk_in(clk), .slow_in(slow), .ready_out(rdy));
   always @(posedge clk) begin
      if (ov && rdy) begin
         got.push_back(dout);
         gp.push_back(opar);
      end
   end
   task cmp(string s, logic [7:0] e, logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s exp %h got %h", s, e, g);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // One operation: mode rise, bytes in, block end, compare
   task xfer(stc_pkg::stc_op_t k, logic dis, logic [7:0] d[$],
             logic [7:0] e[$], logic c);
      got = {};
      gp = {};
      op <= k;
      mp1 <= {5'h0, dis, 2'h0};
      top <= 1;
      foreach (d[i]) begin
         @(posedge clk);
         vld <= 1;
         din <= d[i];
         par <= ~^d[i];
         do @(negedge clk); while (!irdy);
      end
      @(posedge clk);
      vld <= 0;
      repeat (20) @(posedge clk);
      eob <= 1;
      @(posedge clk);
      eob <= 0;
      repeat (20) @(posedge clk);
      top <= 0;
      cmp("count", 8'(e.size()), 8'(got.size()));
      foreach (e[i]) cmp("data", e[i], got[i]);
      foreach (e[i]) cmp("parity", {7'h0, ~^e[i]}, {7'h0, gp[i]});
      cmp("check", {7'h0, c}, {7'h0, ck});
      cmp("enable", {7'h0, !dis}, {7'h0, en});
      @(posedge clk);
   endtask
   task t_off;
      xfer(stc_pkg::STC_OP_WRITE, 1, '{8'h23}, '{8'h23}, 0);
   endtask
   task t_write;
      slow <= 1;
      xfer(stc_pkg::STC_OP_WRITE, 0, '{8'ha5, 8'h3c, 8'h0f, 8'hff},
         '{8'h29, 8'h13, 8'h30, 8'h0f, 8'h3f, 8'h30}, 0);
      slow <= 0;
   endtask
   task t_read;
      xfer(stc_pkg::STC_OP_READ_FWD, 0, '{8'h29, 8'h13, 8'h30, 8'h0f,
         8'h3f, 8'h30}, '{8'ha5, 8'h3c, 8'h0f, 8'hff, 8'h00}, 1);
   endtask
   task t_bwd;
      xfer(stc_pkg::STC_OP_READ_BWD, 0, '{8'h2a}, '{8'h2a}, 0);
   endtask
   task t_nine;
      seven <= 0;
      xfer(stc_pkg::STC_OP_WRITE, 0, '{8'hc3}, '{8'hc3}, 0);
      seven <= 1;
   endtask
   task t_other;
      xfer(stc_pkg::STC_OP_OTHER, 0, '{8'h5a}, '{8'h5a}, 0);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1;
      @(posedge clk);
      t_off();
      t_write();
      t_read();
      t_bwd();
      t_nine();
      t_other();
      stop_test();
   end
   initial begin
      #20000;
      n_mismatch++;
      stop_test();
   end
endmodule
`default_nettype wire
